// *** logic/dam_pkg.sv ***
// shared types and constants of the drive I/O assembly mapper
// assumes one 20 MHz clock; requests and status arrive synchronous to it
//
// Overview of operation
// - six static assemblies: outputs 20, 21, 100; inputs 70, 71, 150
// - output instances readable and writable, input instances read only
// - get-single-attribute 0x0E answered at class and instance level
// - set-single-attribute 0x10 accepted only on output instances, never class level
// - each instance's byte array lives in attribute 3
// - no object-specific services on static assemblies
// - stored parameter picks one of three sets; takes effect after drive reset
// - basic output: run-forward b0.0, fault-reset b0.2, speed reference bytes 2-3
// - extended output adds run-reverse b0.1, network control b0.5, reference b0.6
// - vendor output byte 0 command bits; bytes 0-1 form command word 101
// - vendor output byte 1: jog through command priority
// - vendor output frequency bytes 2-3, command data words bytes 4-5, 6-7
// - basic input: faulted b0.0, running-forward b0.2, actual speed bytes 2-3
// - extended input byte 0 flags, drive state byte 1, speed bytes 2-3
// - vendor input byte 0 status bits; bytes 0-1 form status word 111
// - vendor input byte 1: jog through ready excluding main power off
// - vendor input output frequency bytes 2-3, status data words 4-5, 6-7
// - set to non-settable attribute: service-not-supported, attribute unchanged
package dam_pkg;

    // -------------------------------------------------------------
    // services, instances, attributes
    // -------------------------------------------------------------
    localparam logic [7:0] SVC_GET      = 8'h0E;
    localparam logic [7:0] SVC_SET      = 8'h10;
    localparam logic [7:0] INST_OUT_BAS = 8'h14;  // 20
    localparam logic [7:0] INST_OUT_EXT = 8'h15;  // 21
    localparam logic [7:0] INST_OUT_VND = 8'h64;  // 100
    localparam logic [7:0] INST_IN_BAS  = 8'h46;  // 70
    localparam logic [7:0] INST_IN_EXT  = 8'h47;  // 71
    localparam logic [7:0] INST_IN_VND  = 8'h96;  // 150
    localparam logic [7:0] ATTR_REV     = 8'h01;
    localparam logic [7:0] ATTR_DATA    = 8'h03;
    localparam logic [15:0] CLASS_REV   = 16'h0002;

    // -------------------------------------------------------------
    // answer codes and lengths
    // -------------------------------------------------------------
    localparam logic [7:0] ST_OK        = 8'h00;
    localparam logic [7:0] ST_SVC_NSUP  = 8'h08;
    localparam logic [7:0] ST_ATTR_NSUP = 8'h14;
    localparam logic [7:0] ST_NO_OBJ    = 8'h16;
    localparam logic [3:0] LEN_SHORT    = 4'h4;
    localparam logic [3:0] LEN_LONG     = 4'h8;
    localparam logic [3:0] LEN_REV      = 4'h2;

    // -------------------------------------------------------------
    // assembly sets and output masks of assigned bits
    // -------------------------------------------------------------
    localparam logic [1:0] SET_BASIC    = 2'h0;
    localparam logic [1:0] SET_EXT      = 2'h1;
    localparam logic [1:0] SET_VENDOR   = 2'h2;
    localparam logic [31:0] MASK_BAS    = 32'hFFFF_0005;
    localparam logic [31:0] MASK_EXT    = 32'hFFFF_0067;
    localparam logic [63:0] MASK_VND    = 64'hFFFF_FFFF_FFFF_FFFD;
    localparam int          FIFO_DEPTH  = 8;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  service;
        logic        class_level;
        logic [7:0]  instance_id;
        logic [7:0]  attribute;
        logic [63:0] data;
    } dam_req_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [3:0]  length;
        logic [63:0] data;
    } dam_rsp_t;

    typedef struct packed {
        logic        run_fwd;
        logic        run_rev;
        logic        fault_reset;
        logic        network_control_select;
        logic        network_reference_select;
        logic [15:0] speed_ref;
        logic        vendor_active;
        logic [15:0] command_word;
        logic [15:0] freq_cmd;
        logic [15:0] command_data_word_a_param;
        logic [15:0] command_data_word_b_param;
    } dam_cmd_t;

    typedef struct packed {
        logic        faulted;
        logic        warning;
        logic        running_fwd;
        logic        running_rev;
        logic        ready;
        logic        ctrl_from_net;
        logic        ref_from_net;
        logic        at_reference;
        logic [7:0]  drive_state;
        logic [15:0] speed_actual;
        logic [15:0] status_word;
        logic [15:0] out_freq;
        logic [15:0] status_data_word_a_param;
        logic [15:0] status_data_word_b_param;
    } dam_sts_t;

    typedef struct packed {
        logic [31:0] out_bas;
        logic [31:0] out_ext;
        logic [63:0] out_vnd;
        logic [1:0]  set_sel;
        logic        loaded;
        logic        rsp_valid;
        dam_rsp_t    rsp;
        logic [63:0] io_in;
        dam_cmd_t    cmd;
    } dam_state_t;

    typedef struct packed {
        logic [2:0] wr;
        logic [2:0] rd;
        logic [3:0] cnt;
    } dam_fifo_state_t;

endpackage

// *** logic/dam_mapper.sv ***
// drive I/O assembly mapper: explicit get/set, polled output FIFO, input image
// assumes requests, polled data and drive status are synchronous to mclk
`timescale 1ns/100ps

// -----------------------------------------------------------------
// polled output buffer
// -----------------------------------------------------------------
module dam_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0]       mem [DEPTH];
    dam_pkg::dam_fifo_state_t f_q;
    dam_pkg::dam_fifo_state_t f_d;
    logic                   push;
    logic                   pop;

    assign in_ready  = (f_q.cnt != 4'(DEPTH));
    assign out_valid = (f_q.cnt != 4'h0);
    assign out_data  = mem[f_q.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        f_d = f_q;
        if (push)
        begin
            f_d.wr = f_q.wr + 3'h1;
        end
        if (pop)
        begin
            f_d.rd = f_q.rd + 3'h1;
        end
        f_d.cnt = f_q.cnt + {3'h0, push} - {3'h0, pop};
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            f_q <= '0;
        end
        else
        begin
            f_q <= f_d;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[f_q.wr] <= in_data;
        end
    end
endmodule

// -----------------------------------------------------------------
// mapper top
// -----------------------------------------------------------------
module dam_mapper (
    // clock and reset
    input  wire logic            mclk,
    input  wire logic            rst_n,
    // explicit messages
    input  wire logic            req_valid,
    input  wire dam_pkg::dam_req_t req,
    output logic                 rsp_valid,
    output dam_pkg::dam_rsp_t    rsp,
    // polled output data from the master
    input  wire logic            io_out_valid,
    output logic                 io_out_ready,
    input  wire logic [63:0]     io_out_data,
    // polled input image to the master
    output logic [63:0]          io_in_data,
    // drive side
    input  wire logic [1:0]      assembly_set_parameter,
    input  wire logic            drive_reset,
    input  wire dam_pkg::dam_sts_t sts,
    output dam_pkg::dam_cmd_t    cmd,
    output logic [1:0]           active_set
);
    dam_pkg::dam_state_t st_q;
    dam_pkg::dam_state_t st_d;
    logic                fifo_valid;
    logic                fifo_pop;
    logic [63:0]         fifo_data;
    logic [31:0]         img_bas;
    logic [31:0]         img_ext;
    logic [63:0]         img_vnd;
    logic                is_out;
    logic                is_in;
    logic                req_set;

    // explicit set takes the cycle; polled data waits so that no write is lost
    assign req_set  = req_valid && (req.service == dam_pkg::SVC_SET);
    assign fifo_pop = fifo_valid && !req_set;

    dam_fifo #(
        .WIDTH (64),
        .DEPTH (dam_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (io_out_valid),
        .in_ready  (io_out_ready),
        .in_data   (io_out_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // -------------------------------------------------------------
    // input images, unassigned bits zero
    // -------------------------------------------------------------
    assign img_bas = {sts.speed_actual, 8'h00,
                      5'h00, sts.running_fwd, 1'b0, sts.faulted};
    assign img_ext = {sts.speed_actual, sts.drive_state,
                      sts.at_reference, sts.ref_from_net, sts.ctrl_from_net,
                      sts.ready, sts.running_rev, sts.running_fwd,
                      sts.warning, sts.faulted};
    assign img_vnd = {sts.status_data_word_b_param, sts.status_data_word_a_param,
                      sts.out_freq, sts.status_word};

    assign is_out = (req.instance_id == dam_pkg::INST_OUT_BAS)
                 || (req.instance_id == dam_pkg::INST_OUT_EXT)
                 || (req.instance_id == dam_pkg::INST_OUT_VND);
    assign is_in  = (req.instance_id == dam_pkg::INST_IN_BAS)
                 || (req.instance_id == dam_pkg::INST_IN_EXT)
                 || (req.instance_id == dam_pkg::INST_IN_VND);

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.rsp_valid = 1'b0;

        // set parameter latched only at power-up or drive reset
        if (!st_q.loaded || drive_reset)
        begin
            st_d.set_sel = assembly_set_parameter;
            st_d.loaded  = 1'b1;
        end

        // polled output data lands in the active output instance
        if (fifo_pop)
        begin
            case (st_q.set_sel)
                dam_pkg::SET_BASIC:  st_d.out_bas = fifo_data[31:0] & dam_pkg::MASK_BAS;
                dam_pkg::SET_EXT:    st_d.out_ext = fifo_data[31:0] & dam_pkg::MASK_EXT;
                dam_pkg::SET_VENDOR: st_d.out_vnd = fifo_data & dam_pkg::MASK_VND;
                default:             st_d.out_bas = st_q.out_bas;
            endcase
        end

        if (req_valid)
        begin
            st_d.rsp_valid = 1'b1;
            st_d.rsp       = '{status: dam_pkg::ST_OK, length: 4'h0, data: 64'h0};
            if (req.service == dam_pkg::SVC_GET)
            begin
                if (req.class_level)
                begin
                    if (req.attribute == dam_pkg::ATTR_REV)
                    begin
                        st_d.rsp.length = dam_pkg::LEN_REV;
                        st_d.rsp.data   = {48'h0, dam_pkg::CLASS_REV};
                    end
                    else
                    begin
                        st_d.rsp.status = dam_pkg::ST_ATTR_NSUP;
                    end
                end
                else if (!(is_out || is_in))
                begin
                    st_d.rsp.status = dam_pkg::ST_NO_OBJ;
                end
                else if (req.attribute != dam_pkg::ATTR_DATA)
                begin
                    st_d.rsp.status = dam_pkg::ST_ATTR_NSUP;
                end
                else
                begin
                    case (req.instance_id)
                        dam_pkg::INST_OUT_BAS: st_d.rsp.data = {32'h0, st_q.out_bas};
                        dam_pkg::INST_OUT_EXT: st_d.rsp.data = {32'h0, st_q.out_ext};
                        dam_pkg::INST_OUT_VND: st_d.rsp.data = st_q.out_vnd;
                        dam_pkg::INST_IN_BAS:  st_d.rsp.data = {32'h0, img_bas};
                        dam_pkg::INST_IN_EXT:  st_d.rsp.data = {32'h0, img_ext};
                        default:               st_d.rsp.data = img_vnd;
                    endcase
                    st_d.rsp.length = ((req.instance_id == dam_pkg::INST_OUT_VND)
                                    || (req.instance_id == dam_pkg::INST_IN_VND))
                                    ? dam_pkg::LEN_LONG : dam_pkg::LEN_SHORT;
                end
            end
            else if (req.service == dam_pkg::SVC_SET)
            begin
                if (req.class_level || is_in)
                begin
                    st_d.rsp.status = dam_pkg::ST_SVC_NSUP;
                end
                else if (!is_out)
                begin
                    st_d.rsp.status = dam_pkg::ST_NO_OBJ;
                end
                else if (req.attribute != dam_pkg::ATTR_DATA)
                begin
                    st_d.rsp.status = dam_pkg::ST_SVC_NSUP;
                end
                else
                begin
                    case (req.instance_id)
                        dam_pkg::INST_OUT_BAS:
                            st_d.out_bas = req.data[31:0] & dam_pkg::MASK_BAS;
                        dam_pkg::INST_OUT_EXT:
                            st_d.out_ext = req.data[31:0] & dam_pkg::MASK_EXT;
                        default:
                            st_d.out_vnd = req.data & dam_pkg::MASK_VND;
                    endcase
                end
            end
            else
            begin
                st_d.rsp.status = dam_pkg::ST_SVC_NSUP;
            end
        end

        // commands follow the active output instance
        st_d.cmd = '0;
        case (st_q.set_sel)
            dam_pkg::SET_BASIC:
            begin
                st_d.cmd.run_fwd     = st_d.out_bas[0];
                st_d.cmd.fault_reset = st_d.out_bas[2];
                st_d.cmd.speed_ref   = st_d.out_bas[31:16];
                st_d.io_in           = {32'h0, img_bas};
            end
            dam_pkg::SET_EXT:
            begin
                st_d.cmd.run_fwd                  = st_d.out_ext[0];
                st_d.cmd.run_rev                  = st_d.out_ext[1];
                st_d.cmd.fault_reset              = st_d.out_ext[2];
                st_d.cmd.network_control_select   = st_d.out_ext[5];
                st_d.cmd.network_reference_select = st_d.out_ext[6];
                st_d.cmd.speed_ref                = st_d.out_ext[31:16];
                st_d.io_in                        = {32'h0, img_ext};
            end
            dam_pkg::SET_VENDOR:
            begin
                // command word bits keep their byte 0 / byte 1 positions
                st_d.cmd.vendor_active             = 1'b1;
                st_d.cmd.command_word              = st_d.out_vnd[15:0];
                st_d.cmd.freq_cmd                  = st_d.out_vnd[31:16];
                st_d.cmd.command_data_word_a_param = st_d.out_vnd[47:32];
                st_d.cmd.command_data_word_b_param = st_d.out_vnd[63:48];
                st_d.io_in                         = img_vnd;
            end
            default:
            begin
                // unknown parameter value: drive sees no command, master reads zero
                st_d.io_in = 64'h0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign rsp_valid  = st_q.rsp_valid;
    assign rsp        = st_q.rsp;
    assign io_in_data = st_q.io_in;
    assign cmd        = st_q.cmd;
    assign active_set = st_q.set_sel;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    property p_rsp_follows;
        @(posedge mclk) disable iff (!rst_n)
        req_valid |=> rsp_valid;
    endproperty
    a_rsp_follows: assert property (p_rsp_follows) else $error("no answer to request");

    property p_no_rsp_alone;
        @(posedge mclk) disable iff (!rst_n)
        !req_valid |=> !rsp_valid;
    endproperty
    a_no_rsp_alone: assert property (p_no_rsp_alone) else $error("answer without request");

    property p_set_input_refused;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && req.service == dam_pkg::SVC_SET && is_in)
            |=> rsp.status == dam_pkg::ST_SVC_NSUP;
    endproperty
    a_set_input_refused: assert property (p_set_input_refused)
        else $error("input set taken");

    property p_class_set_refused;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && req.service == dam_pkg::SVC_SET && req.class_level)
            |=> rsp.status != dam_pkg::ST_OK;
    endproperty
    a_class_set_refused: assert property (p_class_set_refused) else $error("class set ok");

    property p_other_svc;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && req.service != dam_pkg::SVC_SET && req.service != dam_pkg::SVC_GET)
            |=> rsp.status == dam_pkg::ST_SVC_NSUP;
    endproperty
    a_other_svc: assert property (p_other_svc) else $error("extra service accepted");

    property p_set_held;
        @(posedge mclk) disable iff (!rst_n)
        st_q.loaded && !drive_reset |=> $stable(st_q.set_sel);
    endproperty
    a_set_held: assert property (p_set_held) else $error("set changed without reset");

    property p_bad_attr_keeps;
        @(posedge mclk) disable iff (!rst_n)
        (req_valid && req.service == dam_pkg::SVC_SET && req.attribute != dam_pkg::ATTR_DATA
            && !fifo_valid) |=> $stable(st_q.out_vnd) && $stable(st_q.out_bas)
            && $stable(st_q.out_ext) && rsp.status != dam_pkg::ST_OK;
    endproperty
    a_bad_attr_keeps: assert property (p_bad_attr_keeps) else $error("bad attribute set");

    property p_reserved_zero;
        @(posedge mclk) disable iff (!rst_n)
        ##1 (st_q.out_bas[15:0] & ~dam_pkg::MASK_BAS[15:0]) == 16'h0
            && st_q.out_vnd[1] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("unassigned bit stored");

    property p_basic_image;
        @(posedge mclk) disable iff (!rst_n)
        st_q.set_sel == dam_pkg::SET_BASIC ##1 st_q.set_sel == dam_pkg::SET_BASIC
            |-> io_in_data[7:0] == {5'h00, $past(sts.running_fwd), 1'b0, $past(sts.faulted)};
    endproperty
    a_basic_image: assert property (p_basic_image) else $error("basic image wrong");

    property p_ext_cmd;
        @(posedge mclk) disable iff (!rst_n)
        st_q.set_sel == dam_pkg::SET_EXT ##1 st_q.set_sel == dam_pkg::SET_EXT
            |-> cmd.run_rev == $past(st_d.out_ext[1]);
    endproperty
    a_ext_cmd: assert property (p_ext_cmd) else $error("run reverse not mapped");
endmodule

// *** test/dam_master_model.sv ***
// fieldbus master model: explicit get/set requests and polled output words
// assumes the bench calls its tasks from a falling edge of mclk
`timescale 1ns/100ps
module dam_master_model (
    // clock
    input  wire logic              mclk,
    // explicit messages
    output dam_pkg::dam_req_t      req,
    output logic                   req_valid,
    input  wire logic              rsp_valid,
    input  wire dam_pkg::dam_rsp_t rsp,
    // polled output
    output logic                   io_out_valid,
    input  wire logic              io_out_ready,
    output logic [63:0]            io_out_data
);
    initial
    begin
        req_valid = 1'b0;
        req = '0;
        io_out_valid = 1'b0;
        io_out_data = '0;
    end

    // one request, answer taken within three cycles
    task automatic xfer(input logic [7:0] s, input logic c, input logic [7:0] i, a,
                        input logic [63:0] d, output dam_pkg::dam_rsp_t r);
        int k;
        req_valid = 1'b1;
        req = '{s, c, i, a, d};
        @(negedge mclk);
        req_valid = 1'b0;
        req.data = ~d; // released lines do not keep the old value
        for (k = 0; k < 3 && rsp_valid !== 1'b1; k++)
            @(negedge mclk);
        r = rsp;
        @(negedge mclk);
    endtask

    // back-to-back sets stall the drain, so the buffer fills until refused
    task automatic fill(output int n, output logic [63:0] last);
        req_valid = 1'b1;
        req = '{dam_pkg::SVC_SET, 1'b0, dam_pkg::INST_OUT_VND, dam_pkg::ATTR_DATA, 64'h0};
        io_out_valid = 1'b1;
        for (n = 0; n < 12 && io_out_ready === 1'b1; n++)
        begin
            io_out_data = {$urandom, $urandom};
            last = io_out_data;
            @(negedge mclk);
        end
        req_valid = 1'b0;
        io_out_valid = 1'b0;
        io_out_data = ~last;
    endtask
endmodule

// *** test/tb_top.sv ***
// bench of the assembly mapper: random data, error table, set changes
// assumes the master model for explicit and polled traffic
`timescale 1ns/100ps
module tb_top;
    logic              mclk;
    logic              rst_n;
    logic              req_valid;
    dam_pkg::dam_req_t req;
    logic              rsp_valid;
    dam_pkg::dam_rsp_t rsp;
    logic              io_out_valid;
    logic              io_out_ready;
    logic [63:0]       io_out_data;
    logic [63:0]       io_in_data;
    logic [1:0]        param;
    logic              drive_reset;
    dam_pkg::dam_sts_t sts;
    dam_pkg::dam_cmd_t cmd;
    logic [1:0]        active_set;
    dam_pkg::dam_rsp_t r;
    logic [63:0]       w;
    int                n;
    int                miscompares;
    int                num_checks;
    localparam logic [7:0] OI [3] = '{8'h14, 8'h15, 8'h64};
    localparam logic [7:0] II [3] = '{8'h46, 8'h47, 8'h96};
    // error table; the class read comes last
    localparam logic [7:0] ES [6] = '{8'h10, 8'h10, 8'h4B, 8'h0E, 8'h0E, 8'h0E};
    localparam logic       EC [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    localparam logic [7:0] EI [6] = '{8'h00, 8'h14, 8'h14, 8'h30, 8'h14, 8'h00};
    localparam logic [7:0] EA [6] = '{8'h03, 8'h01, 8'h03, 8'h03, 8'h02, 8'h01};
    localparam logic [7:0] EX [6] = '{8'h08, 8'h08, 8'h08, 8'h16, 8'h14, 8'h00};

    dam_mapper dam_mapper_inst (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
        .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .io_out_valid(io_out_valid),
        .io_out_ready(io_out_ready), .io_out_data(io_out_data), .io_in_data(io_in_data),
        .assembly_set_parameter(param), .drive_reset(drive_reset), .sts(sts),
        .cmd(cmd), .active_set(active_set));
    dam_master_model master (.mclk(mclk), .req(req), .req_valid(req_valid),
        .rsp_valid(rsp_valid), .rsp(rsp), .io_out_valid(io_out_valid),
        .io_out_ready(io_out_ready), .io_out_data(io_out_data));

    // -------------------------------------------------------------
    // expectations
    // -------------------------------------------------------------
    function automatic logic [63:0] mask(input int s);
        return s == 0 ? 64'(dam_pkg::MASK_BAS)
             : s == 1 ? 64'(dam_pkg::MASK_EXT) : dam_pkg::MASK_VND;
    endfunction
    function automatic logic [63:0] cview(input int s, input dam_pkg::dam_cmd_t c);
        if (s == 2)
            return {c.command_data_word_b_param, c.command_data_word_a_param, c.freq_cmd,
                    c.command_word};
        return {32'h0, c.speed_ref, 9'h0, c.network_reference_select,
                c.network_control_select, 2'h0, c.fault_reset, c.run_rev, c.run_fwd};
    endfunction
    function automatic logic [63:0] img(input int s, input dam_pkg::dam_sts_t t);
        if (s == 2)
            return {t.status_data_word_b_param, t.status_data_word_a_param, t.out_freq,
                    t.status_word};
        if (s == 1)
            return {32'h0, t.speed_actual, t.drive_state, t.at_reference, t.ref_from_net,
                    t.ctrl_from_net, t.ready, t.running_rev, t.running_fwd, t.warning, t.faulted};
        return {32'h0, t.speed_actual, 13'h0, t.running_fwd, 1'b0, t.faulted};
    endfunction
    task automatic chk(input string nm, input logic [63:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // -------------------------------------------------------------
    // sequence
    // -------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial
    begin
        #(50 * 5000);
        miscompares++;
        end_of_test();
    end
    initial
    begin
        miscompares = 0;
        num_checks = 0;
        rst_n = 1'b0;
        param = 2'h0;
        drive_reset = 1'b0;
        sts = '0;
        void'($urandom(68));
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        master.fill(n, w);
        chk("fill", 64'(n), 64'(dam_pkg::FIFO_DEPTH));
        repeat (12) @(negedge mclk);
        chk("drain", cview(0, cmd), w & mask(0));
        for (int e = 0; e < 6; e++)
        begin
            master.xfer(ES[e], EC[e], EI[e], EA[e], 64'h0, r);
            chk("status", 64'(r.status), 64'(EX[e]));
        end
        chk("rev", r.data, 64'(dam_pkg::CLASS_REV));
        chk("revlen", 64'(r.length), 64'h2);
        for (int s = 0; s < 3; s++)
        begin
            param = 2'(s);
            @(negedge mclk);
            chk("hold", 64'(active_set), 64'(s == 0 ? 0 : s - 1));
            drive_reset = 1'b1;
            @(negedge mclk);
            drive_reset = 1'b0;
            repeat (2) @(negedge mclk);
            chk("set", 64'(active_set), 64'(s));
            w = {$urandom, $urandom};
            sts = {$urandom, $urandom, $urandom};
            master.xfer(dam_pkg::SVC_SET, 1'b0, OI[s], dam_pkg::ATTR_DATA, w, r);
            repeat (3) @(negedge mclk);
            chk("cmd", cview(s, cmd), w & mask(s));
            chk("vnd", 64'(cmd.vendor_active), 64'(s == 2));
            master.xfer(dam_pkg::SVC_GET, 1'b0, OI[s], dam_pkg::ATTR_DATA, 64'h0, r);
            chk("get", r.data, w & mask(s));
            chk("len", 64'(r.length), s < 2 ? 64'h4 : 64'h8);
            chk("image", io_in_data, img(s, sts));
            master.xfer(dam_pkg::SVC_SET, 1'b0, II[s], dam_pkg::ATTR_DATA, ~w, r);
            chk("ro", 64'(r.status), 64'(dam_pkg::ST_SVC_NSUP));
            master.xfer(dam_pkg::SVC_GET, 1'b0, II[s], dam_pkg::ATTR_DATA, 64'h0, r);
            chk("in", r.data, img(s, sts));
        end
        master.fill(n, w);
        chk("refill", 64'(n), 64'(dam_pkg::FIFO_DEPTH));
        repeat (12) @(negedge mclk);
        chk("vdrain", cview(2, cmd), w & mask(2));
        param = 2'h3;
        repeat (3) @(negedge mclk);
        chk("keep", 64'(active_set), 64'h2);
        drive_reset = 1'b1;
        @(negedge mclk);
        drive_reset = 1'b0;
        repeat (2) @(negedge mclk);
        chk("none", 64'(active_set), 64'h3);
        chk("zero", io_in_data | cview(2, cmd) | cview(1, cmd), 64'h0);
        end_of_test();
    end
endmodule
